/* File: verilog/afr_frame_rewrite.sv */
// Frame rewrite stage: one registered pass over each frame header and its lookup action.
// Assumes AHB-Lite with this block as the only slave, and headers arriving one per cycle.
`timescale 1ns/100ps
`include "afr_params.svh"

module afr_frame_rewrite
	import afr_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        in_valid,
	input  afr_hdr_t         in_hdr,
	input  afr_action_t      in_act,
	input  afr_route_t       in_route,
	output logic             out_valid,
	output afr_hdr_t         out_hdr,
	output afr_stats_t       out_stats
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction

	function automatic logic is_tbl(input logic [11:0] a);
		return (a & `AFR_OFS_TBL_MASK) == `AFR_OFS_TBL_BASE;
	endfunction

	function automatic logic ip_mc(input logic v4, input logic [127:0] ip);
		return v4 ? (ip[31:28] == `AFR_IP4_MC_PFX) : (ip[127:120] == `AFR_IP6_MC_PFX);
	endfunction

	// Group bit of a MAC address, used by both conditional modes and by the MAC fix-up of AFR_M_SWAP_MAC and AFR_M_SWAP_BOTH.
	function automatic logic mac_mc(input logic [47:0] mac);
		return mac[`AFR_MAC_MC_BIT];
	endfunction

	// Read decode: unmapped offsets return zero so software never sees stale data.
	function automatic logic [31:0] reg_read(input afr_state_t s, input logic [11:0] a);
		logic [31:0] r;
		r = '0;
		if (is_tbl(a)) begin
			r = s.source_ip_table[a[`AFR_TBL_IDX_HI:`AFR_TBL_IDX_LO]];
		end else if (a == `AFR_OFS_CTRL) begin
			r = {27'h000_0000, s.ctrl};
		end else if (a == `AFR_OFS_SWAP_CTRL) begin
			r = {18'h0_0000, s.dmac_partial_bits, s.preset_ttl_value};
		end else if (a == `AFR_OFS_STATUS) begin
			r = s.rewrite_count;
		end
		return r;
	endfunction

	// Router leg counting; a first-lookup drop takes precedence over a second-lookup drop.
	function automatic afr_stats_t leg_stats(
		input logic routed,
		input logic drop_1,
		input logic drop_2,
		input logic igr_sel,
		input logic egr_sel
	);
		afr_stats_t r;
		r = '0;
		if (routed && drop_1) begin
			r.count_ingress_leg = igr_sel;
			r.count_egress_leg = 1'b0;
		end else if (routed && drop_2) begin
			r.count_ingress_leg = 1'b1;
			r.count_egress_leg = egr_sel;
		end else if (routed) begin
			r.count_ingress_leg = 1'b1;
			r.count_egress_leg = 1'b1;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State.

	afr_state_t s_q;
	afr_state_t s_d;
	logic [11:0] a_w;

	assign a_w = haddr[11:0];

	////////////////////////////////////////////////////////////////////////////////
	// IPv6 view of the table: each entry is four consecutive words, most significant last.

	logic [127:0] v6_entry [`AFR_IP6_ENTRIES];

	generate
		for (genvar g = 0; g < `AFR_IP6_ENTRIES; g++) begin : g_v6
			assign v6_entry[g] = {s_q.source_ip_table[4*g+3], s_q.source_ip_table[4*g+2],
				s_q.source_ip_table[4*g+1], s_q.source_ip_table[4*g]};
		end
	endgenerate

	always_comb begin
		afr_hdr_t     h;
		logic [127:0] tbl_ip;
		logic [47:0]  t48;
		logic [127:0] t128;
		logic         is_ip;
		logic         tbl_ok;
		logic         route;
		logic         sw_mac;
		logic         sw_ip;
		logic         rp_smac;
		logic         rp_sip;
		logic         fx_mac;
		logic         fx_ip;
		logic [15:0]  acc;
		logic [4:0]   ti;
		logic [2:0]   t6;
		h = in_hdr;
		tbl_ip = '0;
		t48 = '0;
		t128 = '0;
		is_ip = in_hdr.is_ipv4 | in_hdr.is_ipv6;
		tbl_ok = ~in_act.policer_enable_action;
		route = s_q.ctrl[`AFR_CTRL_ROUTE_SEL] | (in_act.rewrite_mode_action == AFR_M_ROUTE);
		sw_mac = 1'b0;
		sw_ip = 1'b0;
		rp_smac = 1'b0;
		rp_sip = 1'b0;
		fx_mac = 1'b0;
		fx_ip = 1'b0;
		acc = '0;
		ti = in_act.policer_index_action;
		t6 = in_act.policer_index_action[2:0];
		s_d = s_q;

		// IPv4 entries are single words, IPv6 entries take four consecutive words.
		if (in_hdr.is_ipv4) begin
			tbl_ip = {96'h0, s_q.source_ip_table[ti]};
		end else begin
			tbl_ip = v6_entry[t6];
		end

		////////////////////////////////////////////////////////////////////////////
		// Address mode decode, one mode per frame.

		unique case (in_act.rewrite_mode_action)
			AFR_M_NONE: begin
			end
			AFR_M_ROUTE: begin
			end
			AFR_M_REPL_DMAC: begin
				t48 = in_act.rewrite_command_action[`AFR_REWCMD_PART] ?
					~(`AFR_MAC_ONES >> s_q.dmac_partial_bits) : `AFR_MAC_ONES;
				h.dmac = (in_act.action_mac_address & t48) | (in_hdr.dmac & ~t48);
			end
			AFR_M_REPL_SMAC: begin
				rp_smac = 1'b1;
			end
			AFR_M_SWAP_MAC: begin
				sw_mac = 1'b1;
				fx_mac = 1'b1;
			end
			AFR_M_CSWAP_MAC: begin
				sw_mac = ~mac_mc(in_hdr.dmac);
				rp_smac = mac_mc(in_hdr.dmac);
			end
			AFR_M_SWAP_BOTH: begin
				sw_mac = 1'b1;
				fx_mac = 1'b1;
				sw_ip = 1'b1;
				fx_ip = 1'b1;
			end
			AFR_M_CSWAP_ALL: begin
				sw_mac = ~mac_mc(in_hdr.dmac);
				rp_smac = mac_mc(in_hdr.dmac);
				sw_ip = ~ip_mc(in_hdr.is_ipv4, in_hdr.dip);
				rp_sip = ip_mc(in_hdr.is_ipv4, in_hdr.dip);
			end
			AFR_M_SWAP_IP: begin
				sw_ip = 1'b1;
				fx_ip = 1'b1;
			end
			AFR_M_SMAC_SWIP: begin
				rp_smac = 1'b1;
				sw_ip = 1'b1;
				fx_ip = 1'b1;
			end
			default: begin
			end
		endcase

		////////////////////////////////////////////////////////////////////////////
		// Apply MAC and IP changes.

		if (sw_mac) begin
			h.dmac = in_hdr.smac;
			h.smac = in_hdr.dmac;
		end
		if (rp_smac | (fx_mac & mac_mc(h.smac))) begin
			h.smac = in_act.action_mac_address;
		end
		sw_ip = sw_ip & is_ip;
		rp_sip = rp_sip & is_ip & tbl_ok;
		if (sw_ip) begin
			h.sip = in_hdr.dip;
			h.dip = in_hdr.sip;
		end
		if (rp_sip | (fx_ip & is_ip & tbl_ok & ip_mc(in_hdr.is_ipv4, h.sip))) begin
			h.sip = tbl_ip;
			rp_sip = 1'b1;
		end
		if ((sw_ip | rp_sip) & in_act.ttl_preset_enable) begin
			h.ttl = s_q.preset_ttl_value;
		end
		if (in_act.l4_port_replace_enable & is_ip & in_hdr.is_l4) begin
			h.sport = in_act.rule_tag_value;
			h.dport = in_act.rule_tag_mask;
		end

		////////////////////////////////////////////////////////////////////////////
		// Incremental checksum updates.

		if (in_hdr.is_ipv4) begin
			acc = ~in_hdr.ip4_csum;
			for (int i = 0; i < 2; i++) begin
				acc = oc_add(acc, ~in_hdr.sip[i*16 +: 16]);
				acc = oc_add(acc, h.sip[i*16 +: 16]);
				acc = oc_add(acc, ~in_hdr.dip[i*16 +: 16]);
				acc = oc_add(acc, h.dip[i*16 +: 16]);
			end
			acc = oc_add(acc, ~{in_hdr.ttl, in_hdr.proto});
			acc = oc_add(acc, {h.ttl, h.proto});
			if (h.sip != in_hdr.sip || h.dip != in_hdr.dip || h.ttl != in_hdr.ttl) begin
				h.ip4_csum = ~acc;
			end
		end
		acc = ~in_hdr.l4_csum;
		for (int i = 0; i < 8; i++) begin
			acc = oc_add(acc, ~in_hdr.sip[i*16 +: 16]);
			acc = oc_add(acc, h.sip[i*16 +: 16]);
			acc = oc_add(acc, ~in_hdr.dip[i*16 +: 16]);
			acc = oc_add(acc, h.dip[i*16 +: 16]);
		end
		acc = oc_add(acc, ~in_hdr.sport);
		acc = oc_add(acc, h.sport);
		acc = oc_add(acc, ~in_hdr.dport);
		acc = oc_add(acc, h.dport);
		if (in_hdr.is_l4 && (h.sip != in_hdr.sip || h.dip != in_hdr.dip ||
			h.sport != in_hdr.sport || h.dport != in_hdr.dport)) begin
			h.l4_csum = (in_hdr.is_ipv4 & in_hdr.is_udp) ? `AFR_UDP_ZERO : ~acc;
		end

		////////////////////////////////////////////////////////////////////////////
		// Routing done in this stage.

		if (route) begin
			h.dmac = in_route.next_hop_mac;
			h.no_dmac_rewrite = 1'b1;
			h.vid = in_route.egress_vid;
			if (s_q.ctrl[`AFR_CTRL_VSI_LEG]) begin
				h.vsi = in_route.egress_leg;
			end else if (s_q.ctrl[`AFR_CTRL_VSI_VID]) begin
				h.vsi = in_route.egress_vid;
			end
		end

		////////////////////////////////////////////////////////////////////////////
		// Output stage. The single rewritten header also feeds the mirror copy.

		s_d.out_valid = in_valid;
		if (in_valid) begin
			s_d.out_hdr = h;
			s_d.out_stats = leg_stats(in_hdr.routed, in_hdr.drop_first, in_hdr.drop_second,
				s_q.ctrl[`AFR_CTRL_IGR_CNT], s_q.ctrl[`AFR_CTRL_EGR_CNT]);
			if (h != in_hdr) begin
				s_d.rewrite_count = s_q.rewrite_count + `AFR_ONE32;
			end
		end

		////////////////////////////////////////////////////////////////////////////
		// AHB-Lite slave: zero wait states, always OKAY.

		s_d.hreadyout = 1'b1;
		if (s_q.wr_pend) begin
			if (is_tbl(s_q.wr_addr)) begin
				s_d.source_ip_table[s_q.wr_addr[`AFR_TBL_IDX_HI:`AFR_TBL_IDX_LO]] = hwdata;
			end else if (s_q.wr_addr == `AFR_OFS_CTRL) begin
				s_d.ctrl = hwdata[4:0];
			end else if (s_q.wr_addr == `AFR_OFS_SWAP_CTRL) begin
				s_d.preset_ttl_value = hwdata[`AFR_SWAP_TTL_HI:`AFR_SWAP_TTL_LO];
				s_d.dmac_partial_bits = hwdata[`AFR_SWAP_DBITS_HI:`AFR_SWAP_DBITS_LO];
			end
		end
		s_d.wr_pend = 1'b0;
		if (hsel && htrans[`AFR_HTRANS_NSEQ] && hready) begin
			s_d.wr_pend = hwrite;
			s_d.wr_addr = a_w;
			s_d.hrdata = '0;
			if (!hwrite) begin
				s_d.hrdata = reg_read(s_q, a_w);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
			s_q.preset_ttl_value <= `AFR_RST_TTL;
			s_q.dmac_partial_bits <= `AFR_RST_DBITS;
			s_q.hreadyout <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign hrdata = s_q.hrdata;
	assign hreadyout = s_q.hreadyout;
	assign hresp = s_q.out_stats.count_ingress_leg & 1'b0;
	assign out_valid = s_q.out_valid;
	assign out_hdr = s_q.out_hdr;
	assign out_stats = s_q.out_stats;

endmodule

/* File: verilog/afr_params.svh */
// Constants of the frame rewrite stage: register offsets, field positions, reset values.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
`ifndef AFR_PARAMS_SVH
`define AFR_PARAMS_SVH

`define AFR_ADDR_W        12
`define AFR_OFS_CTRL      12'h000
`define AFR_OFS_SWAP_CTRL 12'h004
`define AFR_OFS_STATUS    12'h008
`define AFR_OFS_TBL_BASE  12'h100
`define AFR_OFS_TBL_MASK  12'hF80
`define AFR_TBL_IDX_HI    6
`define AFR_TBL_IDX_LO    2
`define AFR_IP6_ENTRIES   8

`define AFR_CTRL_ROUTE_SEL 0
`define AFR_CTRL_IGR_CNT   1
`define AFR_CTRL_EGR_CNT   2
`define AFR_CTRL_VSI_LEG   3
`define AFR_CTRL_VSI_VID   4
`define AFR_SWAP_TTL_HI    7
`define AFR_SWAP_TTL_LO    0
`define AFR_SWAP_DBITS_HI  13
`define AFR_SWAP_DBITS_LO  8

`define AFR_RST_TTL        8'h40
`define AFR_RST_DBITS      6'h18
`define AFR_HTRANS_NSEQ    1
`define AFR_REWCMD_PART    9
`define AFR_MAC_MC_BIT     40
`define AFR_MAC_ONES       48'hFFFF_FFFF_FFFF
`define AFR_IP4_MC_PFX     4'hE
`define AFR_IP6_MC_PFX     8'hFF
`define AFR_ONE32          32'h0000_0001
`define AFR_UDP_ZERO       16'h0000

`endif

/* File: verilog/afr_pkg.sv */
// Types shared by the frame rewrite stage.
// Assumes afr_params.svh is on the include path.
package afr_pkg;

	typedef enum logic [3:0] {
		AFR_M_NONE      = 4'h0,
		AFR_M_REPL_DMAC = 4'h1,
		AFR_M_REPL_SMAC = 4'h2,
		AFR_M_SWAP_MAC  = 4'h3,
		AFR_M_CSWAP_MAC = 4'h4,
		AFR_M_SWAP_BOTH = 4'h5,
		AFR_M_CSWAP_ALL = 4'h6,
		AFR_M_SWAP_IP   = 4'h7,
		AFR_M_SMAC_SWIP = 4'h8,
		AFR_M_ROUTE     = 4'h9
	} afr_mode_t;

	typedef struct packed {
		logic [47:0]  dmac;
		logic [47:0]  smac;
		logic         is_ipv4;
		logic         is_ipv6;
		logic         is_l4;
		logic         is_udp;
		logic [127:0] sip;
		logic [127:0] dip;
		logic [7:0]   ttl;
		logic [7:0]   proto;
		logic [15:0]  ip4_csum;
		logic [15:0]  l4_csum;
		logic [15:0]  sport;
		logic [15:0]  dport;
		logic [11:0]  vid;
		logic [11:0]  vsi;
		logic         routed;
		logic         drop_first;
		logic         drop_second;
		logic         mirror_req;
		logic         no_dmac_rewrite;
	} afr_hdr_t;

	typedef struct packed {
		afr_mode_t   rewrite_mode_action;
		logic [47:0] action_mac_address;
		logic [9:0]  rewrite_command_action;
		logic [4:0]  policer_index_action;
		logic        policer_enable_action;
		logic        ttl_preset_enable;
		logic        l4_port_replace_enable;
		logic [15:0] rule_tag_value;
		logic [15:0] rule_tag_mask;
	} afr_action_t;

	typedef struct packed {
		logic [47:0] next_hop_mac;
		logic [11:0] egress_vid;
		logic [11:0] egress_leg;
	} afr_route_t;

	typedef struct packed {
		logic count_ingress_leg;
		logic count_egress_leg;
	} afr_stats_t;

	typedef struct packed {
		logic [4:0]       ctrl;
		logic [7:0]       preset_ttl_value;
		logic [5:0]       dmac_partial_bits;
		logic [31:0][31:0] source_ip_table;
		logic [31:0]      rewrite_count;
		logic             wr_pend;
		logic [11:0]      wr_addr;
		logic [31:0]      hrdata;
		logic             hreadyout;
		logic             out_valid;
		afr_hdr_t         out_hdr;
		afr_stats_t       out_stats;
	} afr_state_t;

endpackage

/* File: tb/afr_frame_rewrite_assertions.sv */
// Checker for the frame rewrite stage.
// Assumes it is bound to afr_frame_rewrite and sees its ports only.
`timescale 1ns/100ps
`include "afr_params.svh"
module afr_frame_rewrite_assertions
	import afr_pkg::*;
(
	input wire logic  hclk,
	input wire logic  hresetn,
	input wire logic  in_valid,
	input afr_hdr_t    in_hdr,
	input afr_action_t in_act,
	input afr_route_t  in_route,
	input wire logic  out_valid,
	input afr_hdr_t    out_hdr,
	input afr_stats_t  out_stats
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	afr_mode_t m;
	assign m = in_act.rewrite_mode_action;
	////////////////////////////////////////////////////////////////////////////
	chk_first_drop: assert property (in_valid && in_hdr.drop_first
		|=> !out_stats.count_egress_leg) else $error("first drop counted at egress");
	chk_second_drop: assert property (in_valid && in_hdr.routed
		&& in_hdr.drop_second && !in_hdr.drop_first
		|=> out_stats.count_ingress_leg) else $error("second drop not counted");
	chk_mirror_same: assert property (in_valid
		|=> out_valid && out_hdr.mirror_req == $past(in_hdr.mirror_req))
		else $error("mirror flag lost");
	chk_smac_repl: assert property (in_valid && m == AFR_M_REPL_SMAC
		|=> out_hdr.smac == $past(in_act.action_mac_address)
		&& out_hdr.sip == $past(in_hdr.sip)) else $error("smac replace wrong");
	chk_swap_mac: assert property (in_valid && m == AFR_M_SWAP_MAC
		&& !in_hdr.dmac[`AFR_MAC_MC_BIT]
		|=> out_hdr.smac == $past(in_hdr.dmac)) else $error("mac swap wrong");
	chk_route_dmac: assert property (in_valid && m == AFR_M_ROUTE
		|=> out_hdr.dmac == $past(in_route.next_hop_mac) && out_hdr.no_dmac_rewrite)
		else $error("route dmac wrong");
	chk_route_vid: assert property (in_valid && m == AFR_M_ROUTE
		|=> out_hdr.vid == $past(in_route.egress_vid)) else $error("route vid wrong");
	chk_idle_pass: assert property (in_valid && m == AFR_M_NONE
		|=> out_hdr.smac == $past(in_hdr.smac) && out_hdr.sip == $past(in_hdr.sip)
		&& out_hdr.dip == $past(in_hdr.dip)) else $error("idle frame changed");
	cov_swap_both: cover property (in_valid && m == AFR_M_SWAP_BOTH);
	cov_first: cover property (in_valid && in_hdr.drop_first);
	cov_route: cover property (out_valid && out_hdr.no_dmac_rewrite);
endmodule

bind afr_frame_rewrite afr_frame_rewrite_assertions i_chk (
	.hclk      (hclk),
	.hresetn   (hresetn),
	.in_valid  (in_valid),
	.in_hdr    (in_hdr),
	.in_act    (in_act),
	.in_route  (in_route),
	.out_valid (out_valid),
	.out_hdr   (out_hdr),
	.out_stats (out_stats)
);

/* File: tb/afr_far_end.sv */
// Far side model: route result of the L3 analyzer and the egress rewriter's last steps.
// Assumes the same clock as the rewrite stage.
`timescale 1ns/100ps
module afr_far_end
	import afr_pkg::*;
#(
	parameter logic [47:0] NEXT_HOP = 48'h0200_0000_0A01,
	parameter logic [47:0] LEG_MAC  = 48'h0200_0000_0B02,
	parameter logic [11:0] EG_VID   = 12'h123,
	parameter logic [11:0] EG_LEG   = 12'h045
)
(
	input  wire logic   hclk,
	input  wire logic   out_valid,
	input  afr_hdr_t    out_hdr,
	output afr_route_t  route,
	output logic [7:0]  eg_ttl,
	output logic [47:0] eg_smac
);
	assign route = '{next_hop_mac: NEXT_HOP, egress_vid: EG_VID, egress_leg: EG_LEG};
	always_ff @(posedge hclk) begin
		if (out_valid) begin
			eg_ttl  <= out_hdr.ttl - 8'h01;
			eg_smac <= out_hdr.no_dmac_rewrite ? LEG_MAC : out_hdr.smac;
		end
	end
endmodule

/* File: tb/afr_frame_rewrite_test.sv */
// Self-checking bench for the frame rewrite stage.
// Assumes the stage is the only bus slave and the far-end model feeds its route input.
`timescale 1ns/100ps
module afr_frame_rewrite_test
	import afr_pkg::*;
;
	localparam logic [47:0]  D = 48'h0000_1111_2222;
	localparam logic [47:0]  S = 48'h0000_3333_4444;
	localparam logic [47:0]  A = 48'h0200_5555_6666;
	localparam logic [47:0]  N = 48'h0200_0000_0A01;
	localparam logic [47:0]  L = 48'h0200_0000_0B02;
	localparam logic [127:0] SI = 128'h0A00_0001;
	localparam logic [127:0] DI = 128'hE000_0001;
	localparam logic [31:0]  T = 32'h0B00_0007;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        in_valid = 1'b0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [1:0]  htrans = '0;
	logic [31:0] hrdata, q;
	logic        hready, hreadyout, hresp, out_valid;
	afr_hdr_t    in_hdr = '0;
	afr_hdr_t    out_hdr, h;
	afr_action_t in_act = '0;
	afr_action_t a;
	afr_route_t  in_route;
	afr_stats_t  out_stats;
	logic [7:0]  eg_ttl;
	logic [47:0] eg_smac;
	int          failures = 0;
	int          n_compared = 0;
	assign hready = hreadyout;
	always #2 hclk = ~hclk;
	afr_frame_rewrite i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .in_valid(in_valid),
		.in_hdr(in_hdr), .in_act(in_act), .in_route(in_route), .out_valid(out_valid),
		.out_hdr(out_hdr), .out_stats(out_stats));
	afr_far_end #(.NEXT_HOP(N), .LEG_MAC(L)) i_far (.hclk(hclk), .out_valid(out_valid),
		.out_hdr(out_hdr), .route(in_route), .eg_ttl(eg_ttl), .eg_smac(eg_smac));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [127:0] got, logic [127:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic bus(logic w, logic [11:0] ad, logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {20'h0_0000, ad};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic base();
		h = '0;
		h.dmac = D;
		h.smac = S;
		h.is_ipv4 = 1'b1;
		h.is_l4 = 1'b1;
		h.is_udp = 1'b1;
		h.sip = SI;
		h.dip = DI;
		h.ttl = 8'h77;
		h.proto = 8'h11;
		h.ip4_csum = 16'h1234;
		h.l4_csum = 16'hBEEF;
		h.vid = 12'h00A;
		h.vsi = 12'h007;
		h.mirror_req = 1'b1;
		a = '0;
		a.action_mac_address = A;
		a.policer_index_action = 5'h03;
		a.ttl_preset_enable = 1'b1;
	endtask
	task automatic send();
		@(posedge hclk);
		in_hdr   <= h;
		in_act   <= a;
		in_valid <= 1'b1;
		@(posedge hclk);
		in_valid <= 1'b0;
		#1;
		chk("out_valid", out_valid, 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		bus(1'b0, 12'h004, 32'h0);
		chk("swap_ctrl", q, 32'h0000_1840);
		chk("hresp", hresp, 1'b0);
		bus(1'b1, 12'h10C, T);
		bus(1'b0, 12'h10C, 32'h0);
		chk("table", q, T);
		bus(1'b1, 12'h00C, 32'hFFFF_FFFF);
		bus(1'b0, 12'h00C, 32'h0);
		chk("unmapped", q, 32'h0);
	endtask
	task automatic t_modes();
		logic [47:0]  mac [4];
		logic [127:0] ip [3];
		int xd [10], xs [10], xi [10], xj [10];
		mac = '{D, S, A, N};
		ip = '{SI, DI, {96'h0, T}};
		xd = '{0, 2, 0, 1, 1, 1, 1, 0, 0, 3};
		xs = '{1, 1, 2, 0, 0, 0, 0, 1, 2, 1};
		xi = '{0, 0, 0, 0, 0, 2, 2, 2, 2, 0};
		xj = '{1, 1, 1, 1, 1, 0, 1, 0, 0, 1};
		bus(1'b1, 12'h004, 32'h0000_1833);
		for (int m = 0; m < 10; m++) begin
			base();
			a.rewrite_mode_action = afr_mode_t'(m);
			send();
			chk("dmac", out_hdr.dmac, mac[xd[m]]);
			chk("smac", out_hdr.smac, mac[xs[m]]);
			chk("sip", out_hdr.sip, ip[xi[m]]);
			chk("dip", out_hdr.dip, ip[xj[m]]);
			chk("mirror", out_hdr.mirror_req, 1'b1);
			chk("ttl", out_hdr.ttl, (xi[m] != 0) ? 8'h33 : 8'h77);
			chk("udp", out_hdr.l4_csum, (xi[m] != 0) ? 16'h0000 : 16'hBEEF);
		end
	endtask
	task automatic t_misc();
		base();
		h.dip = 128'h0A00_0002;
		a.rewrite_mode_action = AFR_M_SWAP_IP;
		a.l4_port_replace_enable = 1'b1;
		a.rule_tag_value = 16'h1F90;
		a.rule_tag_mask = 16'h0050;
		send();
		chk("csum", out_hdr.ip4_csum, 16'h5634);
		chk("ports", {out_hdr.sport, out_hdr.dport}, 32'h1F90_0050);
		base();
		a.rewrite_mode_action = AFR_M_SWAP_IP;
		a.policer_enable_action = 1'b1;
		send();
		chk("sip", out_hdr.sip, DI);
		base();
		a.rewrite_mode_action = AFR_M_REPL_DMAC;
		a.rewrite_command_action = 10'h200;
		send();
		chk("dmac", out_hdr.dmac, {A[47:24], D[23:0]});
	endtask
	task automatic t_route(logic [31:0] c, logic f, logic s, logic [1:0] st, logic [11:0] v);
		bus(1'b1, 12'h000, c);
		base();
		h.routed = 1'b1;
		h.drop_first = f;
		h.drop_second = s;
		send();
		chk("stats", out_stats, st);
		chk("vid", out_hdr.vid, 12'h123);
		chk("vsi", out_hdr.vsi, v);
		chk("dmac", {out_hdr.no_dmac_rewrite, out_hdr.dmac}, {1'b1, N});
		@(posedge hclk);
		#1;
		chk("far", {eg_ttl, eg_smac}, {8'h76, L});
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_modes();
		t_misc();
		t_route(32'h0000_000B, 1'b1, 1'b0, 2'b10, 12'h045);
		t_route(32'h0000_0001, 1'b1, 1'b0, 2'b00, 12'h007);
		t_route(32'h0000_0011, 1'b0, 1'b1, 2'b10, 12'h123);
		t_route(32'h0000_0015, 1'b0, 1'b1, 2'b11, 12'h123);
		report_and_stop();
	end
	initial begin
		repeat (5000) @(posedge hclk);
		failures++;
		report_and_stop();
	end
endmodule
